/* ddr_capture_pkg.sv */
// shared constants and types for the strobe-based read capture block
package ddr_capture_pkg;

  // ==========================================================================
  // group structure
  // ==========================================================================
  localparam int GROUP_COUNT     = 2;
  localparam int GROUP_CELLS     = 14;
  localparam int GROUP_CELLS_ALT = 12;
  localparam int MAX_DATA_WIDTH  = 16;
  localparam int GROUP_DQ_WIDTH  = MAX_DATA_WIDTH / GROUP_COUNT;
  localparam int FIFO_DEPTH      = 8;

  // ==========================================================================
  // delay calibration
  // ==========================================================================
  localparam int         CAL_WIDTH      = 6;
  localparam logic [5:0] CAL_RESET      = 6'h20;
  localparam logic [5:0] CAL_MAX        = 6'h3f;
  localparam logic [5:0] CAL_MIN        = 6'h00;
  localparam logic [3:0] DLL_LOCK_STEPS = 4'h8;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int         CLK_PERIOD_NS    = 8;
  localparam int         PREAMBLE_IDLE_NS = 200;
  localparam int         DLL_STEP_NS      = 32;
  localparam logic [7:0] IDLE_CYCLES      = 8'((PREAMBLE_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DLL_STEP_CYCLES  = 8'((DLL_STEP_NS / CLK_PERIOD_NS) > 0 ? DLL_STEP_NS / CLK_PERIOD_NS : 1);

  // ==========================================================================
  // preamble detector states
  // ==========================================================================
  typedef enum logic [2:0] {
    QUIET_ST = 3'b001,
    ARMED_ST = 3'b010,
    BURST_ST = 3'b100
  } detect_state_e;

endpackage

/* stream_fifo_if.sv */
// valid/ready stream carrier between the capture logic and its crossing fifo
`timescale 1ns/1ps
interface stream_fifo_if #(parameter int WIDTH = 16);
  logic             wclk;
  logic             wresetn;
  logic             wvalid;
  logic             wready;
  logic [WIDTH-1:0] wdata;
  logic             rclk;
  logic             rresetn;
  logic             rvalid;
  logic             rready;
  logic [WIDTH-1:0] rdata;

  modport fifo (input wclk, wresetn, wvalid, wdata, rclk, rresetn, rready,
                output wready, rvalid, rdata);
  modport user (output wclk, wresetn, wvalid, wdata, rclk, rresetn, rready,
                input wready, rvalid, rdata);
endinterface // stream_fifo_if

/* capture_fifo.sv */
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
module capture_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // both stream sides
  stream_fifo_if.fifo bus
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wbin_reg;
  logic [AW:0]      wgray_reg;
  logic [AW:0]      rbin_reg;
  logic [AW:0]      rgray_reg;
  logic [AW:0]      rq1_reg;
  logic [AW:0]      rq2_reg;
  logic [AW:0]      wq1_reg;
  logic [AW:0]      wq2_reg;

  wire              push      = bus.wvalid & bus.wready;
  wire              pop       = bus.rvalid & bus.rready;
  wire [AW:0]       wbin_next = wbin_reg + (AW+1)'(1);
  wire [AW:0]       rbin_next = rbin_reg + (AW+1)'(1);
  wire              full      = (wgray_reg == {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]});

  assign bus.wready = ~full;
  assign bus.rvalid = (rgray_reg != wq2_reg);
  assign bus.rdata  = mem_reg[rbin_reg[AW-1:0]];

  // ==========================================================================
  // write side
  // ==========================================================================
  always_ff @(posedge bus.wclk)
  begin
    if (!bus.wresetn)
    begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
    end
    else if (push)
    begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
    end
  end

  always_ff @(posedge bus.wclk)
  begin
    if (push)
      mem_reg[wbin_reg[AW-1:0]] <= bus.wdata;
  end

  always_ff @(posedge bus.wclk)
  begin
    if (!bus.wresetn)
    begin
      rq1_reg <= '0;
      rq2_reg <= '0;
    end
    else
    begin
      rq1_reg <= rgray_reg;
      rq2_reg <= rq1_reg;
    end
  end

  // ==========================================================================
  // read side
  // ==========================================================================
  always_ff @(posedge bus.rclk)
  begin
    if (!bus.rresetn)
    begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
    end
    else if (pop)
    begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
    end
  end

  always_ff @(posedge bus.rclk)
  begin
    if (!bus.rresetn)
    begin
      wq1_reg <= '0;
      wq2_reg <= '0;
    end
    else
    begin
      wq1_reg <= wgray_reg;
      wq2_reg <= wq1_reg;
    end
  end

  a_fifo_gray_step: assert property (@(posedge bus.wclk) disable iff (!bus.wresetn)
    $countones(wgray_reg ^ $past(wgray_reg)) <= 1)
    else $error("write gray pointer moved more than one bit");

endmodule // capture_fifo

/* ddr_strobe_read_capture.sv */
// strobe control element: shifted strobes, read polarity select, capture stream and delay calibration
//
// Summary of operation
// - two right-edge groups exist, each of 14 or 12 cells with memory circuitry
// - both groups together serve memory data up to 16 bits wide
// - one cell per group makes shifted strobes, polarity and capture-valid signals
// - those strobes and controls reach every cell of the group on dedicated fanout
// - both shifted strobes come from incoming DQS, which is not free-running
// - a polarity selector picks the system clock edge for the synchronizing registers
// - polarity is chosen anew at the start of every read that follows at least 200 ns without a strobe rise
// - first DQS rise after the preamble sets the synchronizer polarity
// - DQS delay takes a 6-bit calibration code from the DLL
// - the DLL tracks process, voltage and temperature with system clock feedback
// - data sampled on both strobe edges, two streams resynchronized to system clock
// - DQ tristate control passes two extra registers clocked by the write strobe; DQS output enable comes straight from ts_reg
`timescale 1ns/1ps
module ddr_strobe_read_capture
  import ddr_capture_pkg::*;
#(
  parameter int CELLS    = GROUP_CELLS,
  parameter int DQ_WIDTH = GROUP_DQ_WIDTH,
  parameter int DEPTH    = FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // strobe pin, input side is the link clock
  input  wire logic                 dqs_strobe_in,
  output logic                      dqs_tx_out,
  output logic                      dqs_oe_n_out,
  // data pins
  input  wire logic [DQ_WIDTH-1:0]  dq_in,
  output logic      [DQ_WIDTH-1:0]  dq_tx_out,
  output logic                      dq_oe_n_out,
  // delay calibration
  input  wire logic                 dll_lead_in,
  output logic      [CAL_WIDTH-1:0] dqs_delay_code_out,
  output logic                      dll_locked_out,
  // core write path
  input  wire logic                 tristate_in,
  input  wire logic [DQ_WIDTH-1:0]  wr_data_in,
  // core read stream
  output logic      [DQ_WIDTH-1:0]  rise_data_out,
  output logic      [DQ_WIDTH-1:0]  fall_data_out,
  output logic                      capture_valid_out,
  input  wire logic                 core_ready_in,
  output logic                      capture_ready_out,
  // group fanout
  output logic      [CELLS-1:0]     read_strobe_shifted_out,
  output logic      [CELLS-1:0]     write_strobe_shifted_out,
  output logic      [CELLS-1:0]     sync_clock_polarity_out,
  output logic      [CELLS-1:0]     capture_valid_cells_out
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  stream_fifo_if #(.WIDTH(2*DQ_WIDTH)) fifo_bus ();

  logic                  lrst_meta_reg;
  logic                  lresetn_reg;
  logic [DQ_WIDTH-1:0]   rise_cap_reg;
  logic                  rise_tog_reg;
  logic                  fall_tog_reg;
  logic                  ts_meta_reg;
  logic                  dq_oe_n_reg;

  logic                  ts_reg;
  logic                  dqs_tx_reg;
  logic [DQ_WIDTH-1:0]   dq_tx_reg;
  logic                  dqs_p_meta_reg;
  logic                  dqs_p_sync_reg;
  logic                  dqs_p_last_reg;
  logic                  dqs_n_meta_reg;
  logic                  dqs_n_sync_reg;
  logic                  dqs_n_ret_reg;
  detect_state_e         state_reg;
  detect_state_e         state_next;
  logic [7:0]            idle_cnt_reg;
  logic [7:0]            idle_cnt_next;
  logic                  pol_reg;
  logic [2*DQ_WIDTH-1:0] neg_stage_reg;
  logic [2*DQ_WIDTH-1:0] out_data_reg;
  logic                  out_valid_reg;

  logic                  lead_meta_reg;
  logic                  lead_sync_reg;
  logic                  lead_last_reg;
  logic [7:0]            step_cnt_reg;
  logic [CAL_WIDTH-1:0]  cal_code_reg;
  logic [CAL_WIDTH-1:0]  cal_code_next;
  logic [3:0]            alt_cnt_reg;
  logic [3:0]            alt_cnt_next;
  logic                  dll_locked_reg;

  // ==========================================================================
  // shifted strobes and group fanout
  // ==========================================================================
  wire read_strobe  = dqs_strobe_in;
  wire write_strobe = ~dqs_strobe_in;

  // one copy per cell; the tools place these on the dedicated group routing
  generate
    for (genvar c = 0; c < CELLS; c++)
    begin : g_cell_fanout
      assign read_strobe_shifted_out[c]  = read_strobe;
      assign write_strobe_shifted_out[c] = write_strobe;
      assign sync_clock_polarity_out[c]  = pol_reg;
      assign capture_valid_cells_out[c]  = out_valid_reg;
    end
  endgenerate

  // ==========================================================================
  // link side: reset sync, dual-edge capture, tristate register
  // ==========================================================================
  // the strobe must toggle while resetn_in is low for this side to reset
  always_ff @(posedge read_strobe)
  begin
    lrst_meta_reg <= resetn_in;
    lresetn_reg   <= lrst_meta_reg;
  end

  always_ff @(posedge read_strobe)
  begin
    rise_cap_reg <= dq_in;
    if (!lresetn_reg)
      rise_tog_reg <= 1'b0;
    else
      rise_tog_reg <= ~rise_tog_reg;
  end

  always_ff @(posedge write_strobe)
  begin
    if (!lresetn_reg)
      fall_tog_reg <= 1'b0;
    else
      fall_tog_reg <= rise_tog_reg;
  end

  // falling-edge data lands straight in the fifo memory, paired with the rise
  assign fifo_bus.wclk    = write_strobe;
  assign fifo_bus.wresetn = lresetn_reg;
  assign fifo_bus.wvalid  = rise_tog_reg ^ fall_tog_reg;
  assign fifo_bus.wdata   = {rise_cap_reg, dq_in};
  assign capture_ready_out = fifo_bus.wready;

  always_ff @(posedge write_strobe)
  begin
    if (!lresetn_reg)
    begin
      ts_meta_reg <= 1'b1;
      dq_oe_n_reg <= 1'b1;
    end
    else
    begin
      ts_meta_reg <= ts_reg;
      dq_oe_n_reg <= ts_meta_reg;
    end
  end

  assign dq_oe_n_out = dq_oe_n_reg;

  // ==========================================================================
  // system side: write drive
  // ==========================================================================
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      ts_reg     <= 1'b1;
      dqs_tx_reg <= 1'b0;
      dq_tx_reg  <= '0;
    end
    else
    begin
      ts_reg     <= tristate_in;
      dqs_tx_reg <= ~tristate_in & ~dqs_tx_reg;
      dq_tx_reg  <= wr_data_in;
    end
  end

  assign dqs_tx_out   = dqs_tx_reg;
  assign dqs_oe_n_out = ts_reg;
  assign dq_tx_out    = dq_tx_reg;

  // ==========================================================================
  // system side: preamble detection and polarity select
  // ==========================================================================
  always_ff @(posedge clk_in)
  begin
    dqs_p_meta_reg <= dqs_strobe_in;
    dqs_p_sync_reg <= dqs_p_meta_reg;
    dqs_p_last_reg <= dqs_p_sync_reg;
    dqs_n_ret_reg  <= dqs_n_sync_reg;
  end

  always_ff @(negedge clk_in)
  begin
    dqs_n_meta_reg <= dqs_strobe_in;
    dqs_n_sync_reg <= dqs_n_meta_reg;
  end

  wire dqs_rise   = dqs_p_sync_reg & ~dqs_p_last_reg;
  wire quiet_done = (idle_cnt_reg == IDLE_CYCLES - 8'h01) & ~dqs_rise;
  // late-half chain still low means the rise fell in the second clock half
  wire pol_pick   = ~dqs_n_ret_reg;
  wire armed_rise = (state_reg == ARMED_ST) & dqs_rise;
  wire in_burst   = (state_reg == BURST_ST);

  always_comb
  begin
    state_next    = state_reg;
    idle_cnt_next = dqs_rise ? 8'h00 : idle_cnt_reg + 8'h01;
    case (state_reg)
      QUIET_ST, BURST_ST:
      begin
        if (quiet_done)
        begin
          state_next    = ARMED_ST;
          idle_cnt_next = 8'h00;
        end
      end
      ARMED_ST:
      begin
        idle_cnt_next = 8'h00;
        if (dqs_rise)
          state_next = BURST_ST;
      end
      default:
      begin
        state_next    = QUIET_ST;
        idle_cnt_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_reg    <= QUIET_ST;
      idle_cnt_reg <= 8'h00;
      pol_reg      <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      idle_cnt_reg <= idle_cnt_next;
      if (armed_rise)
        pol_reg <= pol_pick;
    end
  end

  // ==========================================================================
  // system side: synchronizing registers
  // ==========================================================================
  assign fifo_bus.rclk    = clk_in;
  assign fifo_bus.rresetn = resetn_in;
  assign fifo_bus.rready  = ~out_valid_reg | core_ready_in;

  wire                  take      = fifo_bus.rvalid & fifo_bus.rready;
  wire [2*DQ_WIDTH-1:0] sync_pick = pol_reg ? neg_stage_reg : fifo_bus.rdata;

  always_ff @(negedge clk_in)
  begin
    neg_stage_reg <= fifo_bus.rdata;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else if (fifo_bus.rready)
    begin
      out_valid_reg <= fifo_bus.rvalid;
      if (take)
        out_data_reg <= sync_pick;
    end
  end

  assign rise_data_out     = out_data_reg[2*DQ_WIDTH-1:DQ_WIDTH];
  assign fall_data_out     = out_data_reg[DQ_WIDTH-1:0];
  assign capture_valid_out = out_valid_reg;

  capture_fifo #(
    .WIDTH (2*DQ_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .bus (fifo_bus.fifo)
  );

  // ==========================================================================
  // delay calibration loop
  // ==========================================================================
  wire step       = (step_cnt_reg == DLL_STEP_CYCLES - 8'h01);
  wire alternated = lead_sync_reg ^ lead_last_reg;

  assign cal_code_next = lead_sync_reg ? (cal_code_reg == CAL_MAX ? CAL_MAX : cal_code_reg + 6'h01)
                                       : (cal_code_reg == CAL_MIN ? CAL_MIN : cal_code_reg - 6'h01);
  assign alt_cnt_next  = !alternated ? 4'h0
                       : (alt_cnt_reg == DLL_LOCK_STEPS ? DLL_LOCK_STEPS : alt_cnt_reg + 4'h1);

  always_ff @(posedge clk_in)
  begin
    lead_meta_reg <= dll_lead_in;
    lead_sync_reg <= lead_meta_reg;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      step_cnt_reg   <= 8'h00;
      lead_last_reg  <= 1'b0;
      cal_code_reg   <= CAL_RESET;
      alt_cnt_reg    <= 4'h0;
      dll_locked_reg <= 1'b0;
    end
    else
    begin
      step_cnt_reg <= step ? 8'h00 : step_cnt_reg + 8'h01;
      if (step)
      begin
        lead_last_reg  <= lead_sync_reg;
        cal_code_reg   <= cal_code_next;
        alt_cnt_reg    <= alt_cnt_next;
        dll_locked_reg <= (alt_cnt_next == DLL_LOCK_STEPS);
      end
    end
  end

  assign dqs_delay_code_out = cal_code_reg;
  assign dll_locked_out     = dll_locked_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  a_pol_on_rise: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $changed(pol_reg) |-> $past(armed_rise))
    else $error("polarity changed outside a preamble rise");

  a_pol_burst_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (in_burst && $past(in_burst)) |-> $stable(pol_reg))
    else $error("polarity changed inside a burst");

  a_rearm_each_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == BURST_ST && quiet_done) |=> state_reg == ARMED_ST)
    else $error("detector did not rearm after quiet strobe");

  a_arm_to_burst: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_reg == ARMED_ST && dqs_rise) |=> state_reg == BURST_ST ##1 state_reg != ARMED_ST)
    else $error("first rise did not open a burst");

  a_valid_stands: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (out_valid_reg && !core_ready_in) |=> (out_valid_reg && $stable(out_data_reg)))
    else $error("capture output dropped before it was taken");

  a_sync_edge_pick: assert property (@(posedge clk_in) disable iff (!resetn_in)
    take |=> out_data_reg == ($past(pol_reg) ? $past(neg_stage_reg) : $past(fifo_bus.rdata)))
    else $error("synchronizer took data from the wrong edge stage");

  a_ts_wstrobe: assert property (@(posedge write_strobe) disable iff (!lresetn_reg)
    ($past(ts_meta_reg, 2) == $past(ts_meta_reg)) |-> dq_oe_n_reg == $past(ts_meta_reg))
    else $error("tristate did not pass the write strobe register");

  a_cal_saturate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (step && lead_sync_reg && cal_code_reg == CAL_MAX) |=> cal_code_reg == CAL_MAX)
    else $error("calibration code wrapped at the top");

  a_dll_lock_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(dll_locked_reg) |-> $past(alt_cnt_reg) >= DLL_LOCK_STEPS - 4'h1)
    else $error("lock raised before enough alternating steps");

endmodule // ddr_strobe_read_capture

/* ddr_memory_model.sv */
// far-side memory model: drives strobe and data for read bursts and notes expected words
`timescale 1ns/1ps
module ddr_memory_model #(
  parameter int W = 8
) (
  // phase reference and fifo state
  input  wire logic         clk_in,
  input  wire logic         capture_ready_in,
  // strobe and data pins
  output logic              dqs_en_out,
  output logic              dqs_out,
  output logic [W-1:0]      dq_out
);
  logic [2*W-1:0] exp_q[$];
  logic           refused = 1'b0;

  initial
  begin
    dqs_en_out = 1'b0;
    dqs_out    = 1'b0;
    dq_out     = '0;
  end

  // ==========
  // bus release: strobe left to the termination, data shows its inverse
  task automatic release_bus();
    dqs_en_out = 1'b0;
    dqs_out    = 1'b0;
    dq_out     = ~dq_out;
  endtask

  // strobe edges so that the link-side reset can take
  task automatic wake(input int n);
    dqs_en_out = 1'b1;
    repeat (n)
    begin
      #80 dqs_out = 1'b1;
      #80 dqs_out = 1'b0;
    end
    release_bus();
  endtask

  // ==========
  // read burst: idle, driven-low preamble, then n beats of 160 ns
  task automatic burst(input int n, input real phase);
    logic [W-1:0] a;
    logic [W-1:0] b;
    @(posedge clk_in);
    #phase;
    release_bus();
    #160 dqs_en_out = 1'b1;
    dqs_out = 1'b0;
    #160;
    repeat (n)
    begin
      a = W'($urandom);
      b = W'($urandom);
      dq_out = a;
      #40 dqs_out = 1'b1;
      #40 dq_out = b;
      #39;
      if (capture_ready_in) exp_q.push_back({a, b});
      else refused = 1'b1;
      #1 dqs_out = 1'b0;
      #40;
    end
    release_bus();
  endtask
endmodule // ddr_memory_model

/* ddr_strobe_read_capture_tb.sv */
// self-checking bench for the strobe read capture block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module ddr_strobe_read_capture_tb;
  import ddr_capture_pkg::*;
  localparam int CELLS = GROUP_CELLS;
  localparam int W     = GROUP_DQ_WIDTH;
  // ==========
  // stimulus and pins
  logic clk_in = 1'b0, resetn_in = 1'b0, dll_lead_in = 1'b0, tristate_in = 1'b1, core_ready_in = 1'b0;
  logic [W-1:0] wr_data_in = '0;
  logic hold_ready = 1'b0, wr_phase = 1'b0, dqs_wire, m_en, m_dqs, dqs_tx_out, dqs_oe_n_out, dq_oe_n_out;
  logic [W-1:0] dq_wire, m_dq, dq_tx_out, rise_data_out, fall_data_out;
  logic [CAL_WIDTH-1:0] dqs_delay_code_out;
  logic dll_locked_out, capture_valid_out, capture_ready_out;
  logic [CELLS-1:0] read_strobe_shifted_out, write_strobe_shifted_out;
  logic [CELLS-1:0] sync_clock_polarity_out, capture_valid_cells_out;
  logic [2*W-1:0] exp_w;
  int mismatches = 0;
  int checks = 0;

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) core_ready_in <= !hold_ready && ($urandom % 2 == 1);
  assign dqs_wire = (dqs_oe_n_out === 1'b0) ? dqs_tx_out : (m_en & m_dqs);
  assign dq_wire  = (dq_oe_n_out === 1'b0) ? dq_tx_out : m_dq;

  ddr_memory_model #(.W(W)) mem (.clk_in, .capture_ready_in(capture_ready_out),
    .dqs_en_out(m_en), .dqs_out(m_dqs), .dq_out(m_dq));

  ddr_strobe_read_capture #(.CELLS(CELLS), .DQ_WIDTH(W), .DEPTH(FIFO_DEPTH)) DUT (
    .clk_in, .resetn_in, .dqs_strobe_in(dqs_wire), .dqs_tx_out, .dqs_oe_n_out, .dq_in(dq_wire),
    .dq_tx_out, .dq_oe_n_out, .dll_lead_in, .dqs_delay_code_out, .dll_locked_out, .tristate_in,
    .wr_data_in, .rise_data_out, .fall_data_out, .capture_valid_out, .core_ready_in, .capture_ready_out,
    .read_strobe_shifted_out, .write_strobe_shifted_out, .sync_clock_polarity_out, .capture_valid_cells_out);

  // ==========
  // monitor: fanout copies and the read stream against the noted words
  always @(posedge clk_in)
  begin
    if (resetn_in === 1'b1)
    begin
      `CHK(read_strobe_shifted_out, {CELLS{dqs_wire}})
      `CHK(write_strobe_shifted_out, {CELLS{~dqs_wire}})
      `CHK(capture_valid_cells_out, {CELLS{capture_valid_out}})
      if (!wr_phase && capture_valid_out === 1'b1 && core_ready_in === 1'b1)
      begin
        exp_w = (mem.exp_q.size() > 0) ? mem.exp_q.pop_front() : 'x;
        `CHK({rise_data_out, fall_data_out}, exp_w)
      end
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // tests
  task automatic pol_burst(input int n, input real ph, input logic exp);
    logic [CELLS-1:0] p;
    fork
      mem.burst(n, ph);
      #700 p = sync_clock_polarity_out;
    join
    `CHK(p, {CELLS{exp}})
    `CHK(sync_clock_polarity_out, p)
    $display("read burst of %0d done", n);
  endtask

  task automatic dll_test();
    dll_lead_in <= 1'b1;
    repeat (200) @(posedge clk_in);
    #1 `CHK(dqs_delay_code_out, CAL_MAX)
    `CHK(dll_locked_out, 1'b0)
    @(posedge clk_in);
    repeat (16)
    begin
      dll_lead_in <= ~dll_lead_in;
      repeat (4) @(posedge clk_in);
    end
    #1 `CHK(dll_locked_out, 1'b1)
    @(posedge clk_in);
    dll_lead_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    #1 `CHK(dll_locked_out, 1'b0)
    $display("dll test done");
  endtask

  task automatic write_test();
    wr_phase = 1'b1;
    @(posedge clk_in);
    tristate_in <= 1'b0;
    wr_data_in  <= W'($urandom);
    @(posedge clk_in);
    #1 `CHK(dqs_oe_n_out, 1'b0)
    `CHK(dq_oe_n_out, 1'b1)
    `CHK(dq_tx_out, wr_data_in)
    `CHK(dqs_tx_out, 1'b1)
    @(posedge clk_in);
    #1 `CHK(dqs_tx_out, 1'b0)
    repeat (8) @(posedge clk_in);
    #1 `CHK(dq_oe_n_out, 1'b0)
    $display("write path test done");
  endtask

  initial
  begin
    void'($urandom(74));
    fork
      mem.wake(4);
      repeat (16) @(posedge clk_in);
    join
    @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 `CHK(dqs_delay_code_out, CAL_RESET)
    `CHK({dqs_oe_n_out, dq_oe_n_out, dqs_tx_out, capture_valid_out, dll_locked_out}, 5'b11000)
    `CHK({rise_data_out, fall_data_out}, {2*W{1'b0}})
    `CHK(sync_clock_polarity_out, {CELLS{1'b0}})
    // two strobe rises let the link-side reset release before the first burst
    mem.wake(2);
    $display("reset test done");
    @(posedge clk_in);
    fork
      dll_test();
      begin
        pol_burst(6, 2.5, 1'b0);
        pol_burst(5, 6.5, 1'b1);
        pol_burst(7, 2.5, 1'b0);
        hold_ready = 1'b1;
        pol_burst(12, 6.5, 1'b1);
        `CHK(mem.refused, 1'b1)
        hold_ready = 1'b0;
        for (int i = 0; i < 600 && mem.exp_q.size() > 0; i++) @(posedge clk_in);
        repeat (8) @(posedge clk_in);
        #1 `CHK(capture_valid_out, 1'b0)
        `CHK(mem.exp_q.size(), 0)
        $display("fill and drain done");
      end
    join
    write_test();
    wrap_up();
  end

  initial
  begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule // ddr_strobe_read_capture_tb
